/* File: core/pdr_pkg.sv */
// constants, field layouts and types of the power dip ride-through block
// assumes a 200 MHz control clock and a plain one-cycle register port
//
// Notes on behaviour
// RQ1: keep motor powered while dip within hold time
// RQ2: remove motor power once dip exceeds hold
// RQ3: drop servo ready when dip exceeds hold
// RQ4: restore motor power when main supply returns
// RQ5: control supply failure acts as normal power-off
// RQ6: undervoltage alarm during dip overrides hold time
// RQ7: bus voltage low raises warning, limits current
// RQ8: mode field off/host/drive, applied on restart
// RQ9: host applies torque limit on warning
// RQ10: host releases its limit after warning clears
// RQ11: drive mode limits torque to programmed percentage
// RQ12: drive keeps limit for release time after clear
// RQ13: configure hold time 1000 ms with dip function
// RQ14: torque limit keeps reference below acceleration torque
// RQ15: vertical axis limit not below holding torque
// RQ16: millisecond counters start, compare, clear with condition
package pdr_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_HOLD = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_TORQ = 8'h08;
  localparam logic [7:0] OFS_REL = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1C;

  // ***********************************************************
  // field limits, reset values and positions
  // ***********************************************************
  localparam logic [15:0] HOLD_MIN = 16'h0014;
  localparam logic [15:0] HOLD_MAX = 16'hC350;
  localparam logic [15:0] HOLD_RST = 16'h0014;
  localparam logic [6:0] TORQ_MAX = 7'h64;
  localparam logic [6:0] TORQ_RST = 7'h32;
  localparam logic [9:0] REL_MAX = 10'h3E8;
  localparam logic [9:0] REL_RST = 10'h064;
  localparam int FUNC_ACT_POS = 4;
  localparam int CMD_RESTART_BIT = 0;

  localparam logic [1:0] FUNC_OFF = 2'h0;
  localparam logic [1:0] FUNC_HOST = 2'h1;
  localparam logic [1:0] FUNC_DRIVE = 2'h2;

  // interrupt status bits
  localparam int EV_DIP = 0;
  localparam int EV_EXPIRE = 1;
  localparam int EV_RECOVER = 2;
  localparam int EV_WARN = 3;
  localparam int EV_WARN_CLR = 4;
  localparam int EV_ALARM = 5;
  localparam int NUM_EV = 6;
  localparam logic [NUM_EV-1:0] MSK_RST = 6'h00;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int ONE_MS_NS = 1_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_CYCLES_DFLT = ONE_MS_NS / CLK_PERIOD_NS;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {ST_RUN, ST_DIP, ST_OFF, ST_ALARM} pdr_state_t;

  typedef struct packed {
    logic [1:0] func;
    logic [6:0] torq;
    logic [9:0] rel;
    logic [15:0] hold;
  } pdr_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdr_bus_t;

endpackage

/* File: core/pdr_top.sv */
// power dip ride-through supervisor with register port and interrupt
// assumes all inputs synchronous to CLOCK and a master that never waits
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module pdr_top import pdr_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DFLT,
  parameter int DIV_W = 18
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic MAIN_PWR_OK,
  input wire logic CTRL_PWR_FAIL,
  input wire logic DC_BUS_LOW,
  input wire logic UV_ALARM,
  input wire logic SERVO_ON_REQ,
  output logic MOTOR_POWER_EN,
  output logic SERVO_READY,
  output logic UV_WARNING,
  output logic CURRENT_LIMIT_EN,
  output logic TORQUE_LIMIT_EN,
  output logic [6:0] TORQUE_LIMIT_PCT,
  output logic IRQ
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

  // ***********************************************************
  // register port and interrupt state
  // ***********************************************************
  pdr_bus_t bus;
  pdr_cfg_t cfg_ff, nxt_cfg;
  logic [NUM_EV-1:0] irq_st_ff, nxt_irq_st;
  logic [NUM_EV-1:0] irq_msk_ff, nxt_irq_msk;
  logic [NUM_EV-1:0] ev;
  logic [31:0] rdata_ff, nxt_rdata;
  logic restart_ff, nxt_restart;
  logic irq_ff, nxt_irq;

  // supervisory state
  pdr_state_t state_ff, nxt_state;
  logic [1:0] act_func_ff, nxt_act_func;
  logic [15:0] dip_ms_ff, nxt_dip_ms;
  logic [DIV_W-1:0] dip_pre_ff, nxt_dip_pre;
  logic [9:0] rel_ms_ff, nxt_rel_ms;
  logic [DIV_W-1:0] rel_pre_ff, nxt_rel_pre;
  logic warn_ff, nxt_warn;
  logic lim_ff, nxt_lim;
  logic motor_ff, nxt_motor;
  logic ready_ff, nxt_ready;
  logic [6:0] pct_ff, nxt_pct;

  assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_irq_msk = irq_msk_ff;
    nxt_restart = 1'b0;
    nxt_rdata = 32'h0000_0000;
    // a new event wins over a write-one clear in the same cycle
    nxt_irq_st = irq_st_ff;
    if (bus.wr && bus.addr == OFS_IRQ_ST) begin
      nxt_irq_st = irq_st_ff & ~bus.wdata[NUM_EV-1:0];
    end
    nxt_irq_st = nxt_irq_st | ev;
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_HOLD: begin
          // out-of-range settings are clamped, not refused
          if (bus.wdata[15:0] < HOLD_MIN) begin
            nxt_cfg.hold = HOLD_MIN;
          end else if (bus.wdata[15:0] > HOLD_MAX) begin
            nxt_cfg.hold = HOLD_MAX;
          end else begin
            nxt_cfg.hold = bus.wdata[15:0];
          end
        end
        OFS_FUNC: begin
          // held pending until restart, see RQ8
          if (bus.wdata[1:0] <= FUNC_DRIVE) begin
            nxt_cfg.func = bus.wdata[1:0];
          end
        end
        OFS_TORQ: begin
          if (bus.wdata[6:0] > TORQ_MAX || bus.wdata[31:7] != 25'h0) begin
            nxt_cfg.torq = TORQ_MAX;
          end else begin
            nxt_cfg.torq = bus.wdata[6:0];
          end
        end
        OFS_REL: begin
          if (bus.wdata[9:0] > REL_MAX || bus.wdata[31:10] != 22'h0) begin
            nxt_cfg.rel = REL_MAX;
          end else begin
            nxt_cfg.rel = bus.wdata[9:0];
          end
        end
        OFS_CMD: nxt_restart = bus.wdata[CMD_RESTART_BIT];
        OFS_IRQ_MSK: nxt_irq_msk = bus.wdata[NUM_EV-1:0];
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_HOLD: nxt_rdata = {16'h0000, cfg_ff.hold};
        OFS_FUNC: begin
          nxt_rdata = {30'h0, cfg_ff.func};
          nxt_rdata[FUNC_ACT_POS +: 2] = act_func_ff;
        end
        OFS_TORQ: nxt_rdata = {25'h0, cfg_ff.torq};
        OFS_REL: nxt_rdata = {22'h0, cfg_ff.rel};
        OFS_STAT: nxt_rdata = {26'h0, lim_ff, warn_ff, ready_ff, motor_ff,
                               state_ff};
        OFS_IRQ_ST: nxt_rdata = {26'h0, irq_st_ff};
        OFS_IRQ_MSK: nxt_rdata = {26'h0, irq_msk_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_irq = |(nxt_irq_st & nxt_irq_msk);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cfg_ff <= '{func: FUNC_OFF, torq: TORQ_RST, rel: REL_RST,
                  hold: HOLD_RST};
      irq_st_ff <= 6'h00;
      irq_msk_ff <= MSK_RST;
      rdata_ff <= 32'h0000_0000;
      restart_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      irq_st_ff <= nxt_irq_st;
      irq_msk_ff <= nxt_irq_msk;
      rdata_ff <= nxt_rdata;
      restart_ff <= nxt_restart;
      irq_ff <= nxt_irq;
    end
  end

  // ***********************************************************
  // supervisory state machine and millisecond timers
  // ***********************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_act_func = act_func_ff;
    nxt_dip_ms = dip_ms_ff;
    nxt_dip_pre = dip_pre_ff;
    nxt_rel_ms = rel_ms_ff;
    nxt_rel_pre = rel_pre_ff;
    nxt_lim = lim_ff;
    ev = 6'h00;
    unique case (state_ff)
      ST_RUN: begin
        if (UV_ALARM) begin
          nxt_state = ST_ALARM;
        end else if (!MAIN_PWR_OK) begin
          nxt_state = ST_DIP;
          ev[EV_DIP] = 1'b1;
        end
      end
      ST_DIP: begin
        if (UV_ALARM) begin
          nxt_state = ST_ALARM; // see RQ6
        end else if (MAIN_PWR_OK) begin
          nxt_state = ST_RUN; // see RQ1
          ev[EV_RECOVER] = 1'b1;
        end else if (dip_ms_ff > cfg_ff.hold) begin
          nxt_state = ST_OFF; // see RQ2
          ev[EV_EXPIRE] = 1'b1;
        end
      end
      ST_OFF: begin
        if (UV_ALARM) begin
          nxt_state = ST_ALARM;
        end else if (MAIN_PWR_OK && !CTRL_PWR_FAIL) begin
          nxt_state = ST_RUN; // see RQ4
          ev[EV_RECOVER] = 1'b1;
        end
      end
      ST_ALARM: ;
    endcase
    // the alarm is latched until a restart clears it
    if (restart_ff) begin
      nxt_state = MAIN_PWR_OK ? ST_RUN : ST_OFF;
      nxt_act_func = cfg_ff.func; // see RQ8
    end
    // lost control supply behaves as a normal power-off
    if (CTRL_PWR_FAIL && state_ff != ST_ALARM) begin
      nxt_state = ST_OFF; // see RQ5
    end
    if (nxt_state == ST_ALARM && state_ff != ST_ALARM) begin
      ev[EV_ALARM] = 1'b1;
    end
    // interruption timer runs only inside the dip, see RQ16
    if (state_ff == ST_DIP && nxt_state == ST_DIP) begin
      if (dip_pre_ff == DIV_LAST) begin
        nxt_dip_pre = '0;
        nxt_dip_ms = dip_ms_ff + 16'h0001;
      end else begin
        nxt_dip_pre = dip_pre_ff + 1'b1;
      end
    end else begin
      nxt_dip_pre = '0;
      nxt_dip_ms = 16'h0000;
    end
    // warning and current limit only when detection is on, see RQ7
    nxt_warn = (act_func_ff != FUNC_OFF) && DC_BUS_LOW;
    if (nxt_warn && !warn_ff) begin
      ev[EV_WARN] = 1'b1;
    end
    if (!nxt_warn && warn_ff) begin
      ev[EV_WARN_CLR] = 1'b1;
    end
    // in host mode the host does the torque limiting itself
    if (act_func_ff != FUNC_DRIVE) begin
      nxt_lim = 1'b0;
      nxt_rel_ms = 10'h000;
      nxt_rel_pre = '0;
    end else if (warn_ff) begin
      nxt_lim = 1'b1; // see RQ11
      nxt_rel_ms = 10'h000;
      nxt_rel_pre = '0;
    end else if (lim_ff) begin
      if (rel_ms_ff >= cfg_ff.rel) begin
        nxt_lim = 1'b0; // see RQ12
        nxt_rel_ms = 10'h000;
        nxt_rel_pre = '0;
      end else if (rel_pre_ff == DIV_LAST) begin
        nxt_rel_pre = '0;
        nxt_rel_ms = rel_ms_ff + 10'h001; // see RQ16
      end else begin
        nxt_rel_pre = rel_pre_ff + 1'b1;
      end
    end
    nxt_ready = (nxt_state == ST_RUN) || (nxt_state == ST_DIP); // see RQ3
    nxt_motor = SERVO_ON_REQ && nxt_ready;
    // clamped at write, so the limit never exceeds rated torque
    nxt_pct = cfg_ff.torq; // see RQ14
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_ff <= ST_RUN;
      act_func_ff <= FUNC_OFF;
      dip_ms_ff <= 16'h0000;
      dip_pre_ff <= '0;
      rel_ms_ff <= 10'h000;
      rel_pre_ff <= '0;
      warn_ff <= 1'b0;
      lim_ff <= 1'b0;
      motor_ff <= 1'b0;
      ready_ff <= 1'b0;
      pct_ff <= TORQ_RST;
    end else begin
      state_ff <= nxt_state;
      act_func_ff <= nxt_act_func;
      dip_ms_ff <= nxt_dip_ms;
      dip_pre_ff <= nxt_dip_pre;
      rel_ms_ff <= nxt_rel_ms;
      rel_pre_ff <= nxt_rel_pre;
      warn_ff <= nxt_warn;
      lim_ff <= nxt_lim;
      motor_ff <= nxt_motor;
      ready_ff <= nxt_ready;
      pct_ff <= nxt_pct;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign MOTOR_POWER_EN = motor_ff;
  assign SERVO_READY = ready_ff;
  assign UV_WARNING = warn_ff;
  assign CURRENT_LIMIT_EN = warn_ff;
  assign TORQUE_LIMIT_EN = lim_ff;
  assign TORQUE_LIMIT_PCT = pct_ff;
  assign IRQ = irq_ff;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence dip_quiet;
    !CTRL_PWR_FAIL && !UV_ALARM && !restart_ff && !MAIN_PWR_OK;
  endsequence

  sequence dip_over;
    state_ff == ST_DIP && dip_ms_ff > cfg_ff.hold;
  endsequence

  sequence rel_done;
    act_func_ff == FUNC_DRIVE && lim_ff && !warn_ff &&
      rel_ms_ff >= cfg_ff.rel;
  endsequence

  hold_keep_a: assert property ( // see RQ1
    state_ff == ST_DIP && dip_ms_ff <= cfg_ff.hold and dip_quiet
    |=> state_ff == ST_DIP && SERVO_READY)
    else $error("dip left early within hold time");

  hold_expire_a: assert property ( // see RQ2
    dip_over and dip_quiet |=> state_ff == ST_OFF && !MOTOR_POWER_EN)
    else $error("motor still powered after hold time");

  ready_drop_a: assert property ( // see RQ3
    state_ff == ST_OFF || state_ff == ST_ALARM |-> !SERVO_READY)
    else $error("servo ready high while powered off");

  recover_a: assert property ( // see RQ4
    state_ff == ST_OFF && MAIN_PWR_OK && !CTRL_PWR_FAIL && !UV_ALARM
    && SERVO_ON_REQ ##1 SERVO_ON_REQ |-> MOTOR_POWER_EN)
    else $error("motor power not restored on recovery");

  ctrl_fail_a: assert property ( // see RQ5
    CTRL_PWR_FAIL && state_ff != ST_ALARM
    |=> state_ff == ST_OFF && !SERVO_READY)
    else $error("control supply loss not treated as power-off");

  dip_alarm_a: assert property ( // see RQ6
    state_ff == ST_DIP && UV_ALARM && !CTRL_PWR_FAIL && !restart_ff
    |=> state_ff == ST_ALARM [*2])
    else $error("alarm in dip not latched");

  warn_set_a: assert property ( // see RQ7
    act_func_ff != FUNC_OFF && DC_BUS_LOW |=> UV_WARNING && CURRENT_LIMIT_EN)
    else $error("warning or current limit missing");

  warn_off_a: assert property ( // see RQ8
    act_func_ff == FUNC_OFF |=> !UV_WARNING)
    else $error("warning raised with detection disabled");

  drive_lim_a: assert property ( // see RQ11
    act_func_ff == FUNC_DRIVE && warn_ff |=> TORQUE_LIMIT_EN
    && TORQUE_LIMIT_PCT == $past(cfg_ff.torq))
    else $error("drive torque limit not applied");

  rel_end_a: assert property ( // see RQ12
    rel_done |=> !TORQUE_LIMIT_EN ##1 (!TORQUE_LIMIT_EN
    || $past(UV_WARNING)))
    else $error("torque limit not released after delay");

  rel_hold_a: assert property ( // see RQ12
    act_func_ff == FUNC_DRIVE && lim_ff && rel_ms_ff < cfg_ff.rel
    |=> TORQUE_LIMIT_EN)
    else $error("torque limit released early");

  dip_clear_a: assert property ( // see RQ16
    state_ff != ST_DIP |=> dip_ms_ff == 16'h0000 && dip_pre_ff == '0)
    else $error("interruption counter not cleared");

  dip_tick_a: assert property ( // see RQ16
    state_ff == ST_DIP && dip_pre_ff == DIV_LAST && dip_ms_ff <= cfg_ff.hold
    and dip_quiet |=> dip_ms_ff == $past(dip_ms_ff) + 16'h0001)
    else $error("interruption counter missed a tick");

  pct_range_a: assert property ( // see RQ14
    TORQUE_LIMIT_PCT <= TORQ_MAX)
    else $error("torque limit above rated torque");

endmodule

/* File: testbench/pdr_host_model.sv */
// host controller model facing the ride-through block
// assumes the block's warning output is registered on the same clock
`timescale 1ns/100ps
module pdr_host_model import pdr_pkg::*; #(
  parameter logic [6:0] HOST_LIMIT_PCT = 7'h3C
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic uv_warning,
  output logic servo_on_req,
  output logic host_limit,
  output logic [6:0] host_limit_pct
);
  // ****************************
  // host reaction to the warning
  // ****************************
  // the limit follows the warning by one cycle, never drops before it
  always_ff @(posedge clk) begin
    if (rst) begin
      servo_on_req <= 1'b0;
      host_limit <= 1'b0;
    end else begin
      servo_on_req <= 1'b1;
      host_limit <= uv_warning;
    end
  end

  // fixed value: above holding torque, below acceleration torque
  assign host_limit_pct = HOST_LIMIT_PCT;
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the power dip ride-through block
// assumes pdr_pkg and pdr_top compiled first, shortened ms tick
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  error_cnt++; end end
module testbench import pdr_pkg::*; ;
  localparam int MS = 4;
  logic CLOCK, SYS_RST, REG_WR, REG_RD;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, rdat;
  logic MAIN_PWR_OK, CTRL_PWR_FAIL, DC_BUS_LOW, UV_ALARM, SERVO_ON_REQ;
  logic MOTOR_POWER_EN, SERVO_READY, UV_WARNING, CURRENT_LIMIT_EN;
  logic TORQUE_LIMIT_EN, IRQ, host_lim;
  logic [6:0] TORQUE_LIMIT_PCT;
  int error_cnt = 0;
  int num_checks = 0;
  int n;

  pdr_top #(.MS_CYCLES(MS), .DIV_W(18)) DUT (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .MAIN_PWR_OK(MAIN_PWR_OK), .CTRL_PWR_FAIL(CTRL_PWR_FAIL),
    .DC_BUS_LOW(DC_BUS_LOW), .UV_ALARM(UV_ALARM),
    .SERVO_ON_REQ(SERVO_ON_REQ), .MOTOR_POWER_EN(MOTOR_POWER_EN),
    .SERVO_READY(SERVO_READY), .UV_WARNING(UV_WARNING),
    .CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .TORQUE_LIMIT_EN(TORQUE_LIMIT_EN),
    .TORQUE_LIMIT_PCT(TORQUE_LIMIT_PCT), .IRQ(IRQ));

  pdr_host_model HOST (.clk(CLOCK), .rst(SYS_RST), .uv_warning(UV_WARNING),
    .servo_on_req(SERVO_ON_REQ), .host_limit(host_lim),
    .host_limit_pct());

  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  // ****************************
  // register port and helpers
  // ****************************
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdat);
    `CHK(rdat, e)
  endtask

  task automatic restart();
    wr(OFS_CMD, 32'h0000_0001);
    cyc(5);
  endtask

  // sel 0 watches motor power, 1 the drive torque limit
  task automatic wait_lvl(input int sel, input logic v, input int lim,
                          output int cnt);
    logic s;
    cnt = 0;
    do begin
      cyc(1);
      cnt++;
      s = (sel == 0) ? MOTOR_POWER_EN : TORQUE_LIMIT_EN;
    end while (s !== v && cnt < lim);
    `CHK(s, v)
    if (s !== v) begin
      summarize();
    end
  endtask

  task automatic dip(input int k);
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b0;
    cyc(k);
    `CHK(MOTOR_POWER_EN, 1'b1)
    `CHK(SERVO_READY, 1'b1)
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b1;
    cyc(3);
  endtask

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, error_cnt);
  endtask

  initial begin
    repeat (100000) @(posedge CLOCK);
    error_cnt++;
    summarize();
  end

  // ****************************
  // main sequence
  // ****************************
  initial begin
    SYS_RST = 1'b1;
    REG_ADDR = 8'h00;
    REG_WDATA = 32'h0000_0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    MAIN_PWR_OK = 1'b1;
    CTRL_PWR_FAIL = 1'b0;
    DC_BUS_LOW = 1'b0;
    UV_ALARM = 1'b0;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    cyc(3);
    chk_rd(OFS_HOLD, 32'h0000_0014);
    chk_rd(OFS_TORQ, 32'h0000_0032);
    chk_rd(OFS_REL, 32'h0000_0064);
    chk_rd(OFS_FUNC, 32'h0000_0000);
    chk_rd(8'h40, 32'h0000_0000);
    wr(OFS_HOLD, 32'h0000_0005);
    chk_rd(OFS_HOLD, 32'h0000_0014);
    wr(OFS_HOLD, 32'h0000_C351);
    chk_rd(OFS_HOLD, 32'h0000_C350);
    wr(OFS_HOLD, 32'h0000_03E8);
    chk_rd(OFS_HOLD, 32'h0000_03E8);
    wr(OFS_TORQ, 32'h0000_007F);
    chk_rd(OFS_TORQ, 32'h0000_0064);
    wr(OFS_REL, 32'h0000_07D0);
    chk_rd(OFS_REL, 32'h0000_03E8);
    wr(OFS_HOLD, 32'h0000_0014);
    done("registers");
    // two short dips in a row: the counter must restart each time
    dip(70);
    dip(70);
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b0;
    wait_lvl(0, 1'b0, 200, n);
    `CHK(n > 80 && n <= 90, 1'b1)
    `CHK(SERVO_READY, 1'b0)
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b1;
    wait_lvl(0, 1'b1, 4, n);
    cyc(1);
    `CHK(SERVO_READY, 1'b1)
    done("dips");
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b0;
    cyc(10);
    @(posedge CLOCK);
    CTRL_PWR_FAIL <= 1'b1;
    wait_lvl(0, 1'b0, 3, n);
    @(posedge CLOCK);
    CTRL_PWR_FAIL <= 1'b0;
    MAIN_PWR_OK <= 1'b1;
    wait_lvl(0, 1'b1, 4, n);
    @(posedge CLOCK);
    MAIN_PWR_OK <= 1'b0;
    cyc(5);
    @(posedge CLOCK);
    UV_ALARM <= 1'b1;
    wait_lvl(0, 1'b0, 3, n);
    @(posedge CLOCK);
    UV_ALARM <= 1'b0;
    MAIN_PWR_OK <= 1'b1;
    cyc(10);
    `CHK(MOTOR_POWER_EN, 1'b0)
    rd(OFS_STAT, rdat);
    `CHK(rdat[1:0], 2'h3)
    restart();
    `CHK(MOTOR_POWER_EN, 1'b1)
    done("faults");
    @(posedge CLOCK);
    DC_BUS_LOW <= 1'b1;
    cyc(4);
    `CHK(UV_WARNING, 1'b0)
    wr(OFS_FUNC, 32'h0000_0001);
    cyc(4);
    `CHK(UV_WARNING, 1'b0)
    restart();
    `CHK(UV_WARNING, 1'b1)
    `CHK(CURRENT_LIMIT_EN, 1'b1)
    `CHK(TORQUE_LIMIT_EN, 1'b0)
    `CHK(host_lim, 1'b1)
    @(posedge CLOCK);
    DC_BUS_LOW <= 1'b0;
    cyc(4);
    `CHK(UV_WARNING, 1'b0)
    `CHK(host_lim, 1'b0)
    wr(OFS_TORQ, 32'h0000_0028);
    wr(OFS_REL, 32'h0000_0003);
    wr(OFS_FUNC, 32'h0000_0002);
    restart();
    wr(OFS_FUNC, 32'h0000_0003);
    chk_rd(OFS_FUNC, 32'h0000_0022);
    @(posedge CLOCK);
    DC_BUS_LOW <= 1'b1;
    wait_lvl(1, 1'b1, 4, n);
    `CHK(TORQUE_LIMIT_PCT, 7'h28)
    @(posedge CLOCK);
    DC_BUS_LOW <= 1'b0;
    wait_lvl(1, 1'b0, 30, n);
    `CHK(n >= 12 && n <= 20, 1'b1)
    done("modes");
    // every event kind has fired by now, all still masked from reset
    chk_rd(OFS_IRQ_ST, 32'h0000_003F);
    wr(OFS_IRQ_ST, 32'h0000_003F);
    dip(10);
    chk_rd(OFS_IRQ_ST, 32'h0000_0005);
    `CHK(IRQ, 1'b0)
    wr(OFS_IRQ_MSK, 32'h0000_0001);
    cyc(2);
    `CHK(IRQ, 1'b1)
    wr(OFS_IRQ_ST, 32'h0000_0001);
    cyc(2);
    `CHK(IRQ, 1'b0)
    chk_rd(OFS_IRQ_ST, 32'h0000_0004);
    done("interrupt");
    summarize();
  end
endmodule
